// >>> rtl/smsc_map.svh
// Register offsets, field positions, reset values and timing counts
// Included by the system control block
`ifndef SMSC_MAP_SVH
`define SMSC_MAP_SVH
`define SMSC_SYSCTL_OFF 16'hFFC4
`define SMSC_MODE_OFF 16'hFFC5
`define SMSC_CTRL_OFF 16'hFFC8
`define SMSC_STAT_OFF 16'hFFCC
`define SMSC_SYSCTL_RST 8'h09
`define SMSC_STANDBY_ON_SLEEP_BIT 7
`define SMSC_STS_LSB 4
`define SMSC_RESET_SOURCE_FLAG_BIT 3
`define SMSC_INTERRUPT_EDGE_SELECT_BIT 2
`define SMSC_HIE_BIT 1
`define SMSC_INTERNAL_RAM_ENABLE_BIT 0
`define SMSC_MODE_FIXED 8'hE4
`define SMSC_SETTLE_0 18'h02000
`define SMSC_SETTLE_1 18'h04000
`define SMSC_SETTLE_2 18'h08000
`define SMSC_SETTLE_3 18'h10000
`define SMSC_SETTLE_4 18'h20000
`define SMSC_SETTLE_5F 18'h00400
`endif

// >>> rtl/smsc_pkg.sv
// Types shared by the system mode and standby control block
// Constants live in smsc_map.svh
package smsc_pkg;
  typedef enum logic [2:0] {
    SMSC_RUN = 3'b000,
    SMSC_SLEEP = 3'b001,
    SMSC_SSTBY = 3'b011,
    SMSC_SETTLE = 3'b010,
    SMSC_HSTBY = 3'b110
  } smsc_state_e;
  typedef struct packed {
    logic cpu_halt;
    logic periph_halt;
    logic periph_init;
    logic port_hold;
    logic port_off;
  } smsc_pwr_s;
  typedef struct packed {
    logic expanded;
    logic rom_en;
    logic ext_bus_en;
    logic ports_gpio;
    logic ram_route_ext;
  } smsc_mem_s;
endpackage

// >>> rtl/smsc_ctrl.sv
// System mode decode, system control and mode status registers, power-down
// sequencer with settling counter. APB slave, one clock, sync reset.
`timescale 1ns/1ps
`include "smsc_map.svh"
module smsc_ctrl #(
  parameter bit FLASH_VARIANT = 1'b0,
  parameter int ADDR_W = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pins and CPU events
  input wire logic mode_pin_hi,
  input wire logic mode_pin_lo,
  input wire logic standby_pin_n,
  input wire logic sleep_exec,
  input wire logic wake_irq,
  input wire logic wdt_reset,
  input wire logic nmi_in,
  // Control outputs
  output smsc_pkg::smsc_pwr_s pwr,
  output smsc_pkg::smsc_mem_s mem,
  output logic nmi_req,
  output logic host_en,
  output logic ram_en,
  output logic [1:0] op_mode
);
  initial
  begin
    if (ADDR_W < 16)
      $error("ADDR_W must be at least 16");
    if (ADDR_W > 32)
      $error("ADDR_W must not exceed 32");
  end

  function automatic logic [17:0] settle_len(input logic [2:0] code, input logic flash);
    case (code)
      3'b000: settle_len = `SMSC_SETTLE_0;
      3'b001: settle_len = `SMSC_SETTLE_1;
      3'b010: settle_len = `SMSC_SETTLE_2;
      3'b011: settle_len = `SMSC_SETTLE_3;
      3'b101: settle_len = flash ? `SMSC_SETTLE_5F : `SMSC_SETTLE_4;
      default: settle_len = `SMSC_SETTLE_4;
    endcase
  endfunction

  // Expanded modes: exactly one mode pin high
  function automatic logic mode_expanded(input logic hi, input logic lo);
    mode_expanded = hi ^ lo;
  endfunction

  // Power controls for one sequencer state
  function automatic smsc_pkg::smsc_pwr_s pwr_decode(input smsc_pkg::smsc_state_e s);
    pwr_decode = '0;
    case (s)
      smsc_pkg::SMSC_SLEEP:
        pwr_decode.cpu_halt = 1'b1;
      smsc_pkg::SMSC_SSTBY:
      begin
        pwr_decode.cpu_halt = 1'b1;
        pwr_decode.periph_halt = 1'b1;
        pwr_decode.periph_init = 1'b1;
        pwr_decode.port_hold = 1'b1;
      end
      smsc_pkg::SMSC_SETTLE:
      begin
        pwr_decode.cpu_halt = 1'b1;
        pwr_decode.periph_halt = 1'b1;
        pwr_decode.port_hold = 1'b1;
      end
      smsc_pkg::SMSC_HSTBY:
      begin
        pwr_decode.cpu_halt = 1'b1;
        pwr_decode.periph_halt = 1'b1;
        pwr_decode.periph_init = 1'b1;
        pwr_decode.port_off = 1'b1;
      end
      default:
        pwr_decode = '0;
    endcase
  endfunction

  // Memory map controls from the mode pins and the RAM enable bit
  function automatic smsc_pkg::smsc_mem_s mem_decode(input logic hi, input logic lo,
    input logic ram_on);
    mem_decode.expanded = mode_expanded(hi, lo);
    mem_decode.ext_bus_en = mode_expanded(hi, lo);
    mem_decode.rom_en = hi;
    mem_decode.ports_gpio = hi && lo;
    mem_decode.ram_route_ext = mode_expanded(hi, lo) && !ram_on;
  endfunction

  // Address decode of the four register slots
  function automatic logic reg_hit(input logic [15:0] a);
    case (a)
      `SMSC_SYSCTL_OFF,
      `SMSC_MODE_OFF,
      `SMSC_CTRL_OFF,
      `SMSC_STAT_OFF:
        reg_hit = 1'b1;
      default:
        reg_hit = 1'b0;
    endcase
  endfunction

  // Read word of one register slot
  function automatic logic [31:0] read_word(input logic [15:0] a, input logic [7:0] ctl,
    input logic [1:0] pins, input smsc_pkg::smsc_state_e s);
    case (a)
      `SMSC_SYSCTL_OFF:
        read_word = {24'h00_0000, ctl};
      `SMSC_MODE_OFF:
        read_word = {24'h00_0000, `SMSC_MODE_FIXED | {6'h00, pins}};
      `SMSC_STAT_OFF:
        read_word = {29'h0, s};
      default:
        read_word = 32'h0000_0000;
    endcase
  endfunction

  // Selected edge of the interrupt input
  function automatic logic nmi_edge(input logic rising, input logic now, input logic prev);
    nmi_edge = rising ? (now && !prev) : (!now && prev);
  endfunction

  logic [7:0] sysctl_reg;
  logic [7:0] sysctl_next;
  logic settle_done;
  logic [1:0] mode_latch_reg;
  logic [17:0] settle_cnt_reg;
  logic nmi_prev_reg;
  smsc_pkg::smsc_state_e state_reg;
  smsc_pkg::smsc_state_e state_next;
  logic [17:0] settle_target;
  logic [15:0] addr16;
  logic setup;
  logic wr_sys, rd_mode, hit;

  assign addr16 = paddr[15:0];
  assign setup = psel && !penable;
  assign hit = reg_hit(addr16);
  assign settle_done = settle_cnt_reg >= settle_target - 18'h00001;
  assign wr_sys = psel && penable && pready && pwrite && addr16 == `SMSC_SYSCTL_OFF;
  assign rd_mode = setup && !pwrite && addr16 == `SMSC_MODE_OFF;
  assign settle_target = settle_len(sysctl_reg[`SMSC_STS_LSB +: 3], FLASH_VARIANT);

  // APB handshake: no wait state, answer in the access cycle
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else if (clk_en)
    begin
      pready <= setup;
      pslverr <= setup && !hit;
    end
  end

  // Read data stands for the access cycle only
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      prdata <= 32'h0000_0000;
    else if (clk_en)
    begin
      if (setup && !pwrite)
        prdata <= read_word(addr16, sysctl_reg, {mode_pin_hi, mode_pin_lo},
          state_reg);
      else
        prdata <= 32'h0000_0000;
    end
  end

  // Mode register bits latched on read
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      mode_latch_reg <= 2'h0;
    else if (clk_en && rd_mode)
      mode_latch_reg <= {mode_pin_hi, mode_pin_lo};
  end

  // Next value of the system control register
  always_comb
  begin
    sysctl_next = sysctl_reg;
    if (state_reg == smsc_pkg::SMSC_HSTBY)
    begin
      sysctl_next = `SMSC_SYSCTL_RST;
      sysctl_next[`SMSC_RESET_SOURCE_FLAG_BIT] = sysctl_reg[`SMSC_RESET_SOURCE_FLAG_BIT];
    end
    else if (wr_sys)
    begin
      sysctl_next[7:4] = pwdata[7:4];
      sysctl_next[2:0] = pwdata[2:0];
    end
    if (wdt_reset)
      sysctl_next = `SMSC_SYSCTL_RST & 8'hF7;
  end

  // System control register
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      sysctl_reg <= `SMSC_SYSCTL_RST;
    else if (clk_en)
      sysctl_reg <= sysctl_next;
  end

  // Power-down sequencer
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      smsc_pkg::SMSC_RUN:
        if (sleep_exec)
          state_next = sysctl_reg[`SMSC_STANDBY_ON_SLEEP_BIT] ? smsc_pkg::SMSC_SSTBY : smsc_pkg::SMSC_SLEEP;
      smsc_pkg::SMSC_SLEEP:
        if (wake_irq)
          state_next = smsc_pkg::SMSC_RUN;
      smsc_pkg::SMSC_SSTBY:
        if (wake_irq)
          state_next = smsc_pkg::SMSC_SETTLE;
      smsc_pkg::SMSC_SETTLE:
        if (settle_done)
          state_next = smsc_pkg::SMSC_RUN;
      smsc_pkg::SMSC_HSTBY:
        state_next = smsc_pkg::SMSC_HSTBY;
      default:
        state_next = smsc_pkg::SMSC_RUN;
    endcase
    if (!standby_pin_n)
      state_next = smsc_pkg::SMSC_HSTBY;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      state_reg <= smsc_pkg::SMSC_RUN;
    else if (clk_en)
      state_reg <= state_next;
  end

  // Settling counter
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      settle_cnt_reg <= 18'h00000;
    else if (clk_en)
    begin
      if (state_reg == smsc_pkg::SMSC_SETTLE)
        settle_cnt_reg <= settle_cnt_reg + 18'h00001;
      else
        settle_cnt_reg <= 18'h00000;
    end
  end

  // Edge detect for the non-maskable interrupt
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      nmi_prev_reg <= 1'b1;
      nmi_req <= 1'b0;
    end
    else if (clk_en)
    begin
      nmi_prev_reg <= nmi_in;
      nmi_req <= nmi_edge(sysctl_reg[`SMSC_INTERRUPT_EDGE_SELECT_BIT], nmi_in, nmi_prev_reg);
    end
  end

  // Power controls follow the next state; CPU halt lets it stack on wake-up
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      pwr <= '0;
    else if (clk_en)
      pwr <= pwr_decode(state_next);
  end

  // Mode decode and memory map
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      op_mode <= 2'h0;
      mem <= '0;
    end
    else if (clk_en)
    begin
      op_mode <= {mode_pin_hi, mode_pin_lo};
      mem <= mem_decode(mode_pin_hi, mode_pin_lo, sysctl_reg[`SMSC_INTERNAL_RAM_ENABLE_BIT]);
    end
  end

  // Host port and RAM enables
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      host_en <= 1'b0;
      ram_en <= 1'b1;
    end
    else if (clk_en)
    begin
      host_en <= sysctl_reg[`SMSC_HIE_BIT];
      ram_en <= sysctl_reg[`SMSC_INTERNAL_RAM_ENABLE_BIT];
    end
  end
endmodule

// >>> dv/smsc_ctrl_chk.sv
// Port relations of the system control block
// Bound to smsc_ctrl from the bench top; clk_en low only while the bus is idle
`timescale 1ns/1ps
module smsc_ctrl_chk (
  // Clock, reset, bus
  input wire logic clk, rst_n, clk_en, psel, penable, pready, pslverr,
  input wire logic [15:0] paddr,
  // Pins and outputs
  input wire logic mode_pin_hi, mode_pin_lo, standby_pin_n, wake_irq, nmi_req, ram_en,
  input wire smsc_pkg::smsc_pwr_s pwr,
  input wire smsc_pkg::smsc_mem_s mem,
  input wire logic [1:0] op_mode
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence setup_s;
    clk_en && psel && !penable;
  endsequence
  sequence mode3_s;
    (op_mode == 2'h3)[*3];
  endsequence
  bus_ready_a: assert property (setup_s |=> pready) else $error("no ready");
  ready_pulse_a: assert property (pready |=> !pready) else $error("ready held");
  map_ok_a: assert property (setup_s ##0 paddr == 16'hFFC4 |=> !pslverr)
    else $error("slave error on control");
  single_chip_a: assert property (mode3_s |-> mem.ports_gpio && !mem.ext_bus_en)
    else $error("single chip map");
  ram_reset_a: assert property ($rose(rst_n) |-> ram_en) else $error("ram off");
  hw_enter_a: assert property (!standby_pin_n |-> ##[1:2] pwr.port_off)
    else $error("no hw standby");
  hw_hold_a: assert property (pwr.port_off |=> pwr.port_off) else $error("left standby");
  halt_pair_a: assert property (pwr.periph_halt |-> pwr.cpu_halt)
    else $error("cpu runs");
  settle_halt_a: assert property (pwr.periph_init && !pwr.port_off && wake_irq
    |=> pwr.cpu_halt [*8]) else $error("early release");
  nmi_pulse_a: assert property (nmi_req |=> !nmi_req) else $error("nmi held");
endmodule

// >>> dv/system_mode_standby_control_tb.sv
// Self-checking bench for smsc_ctrl, APB master and pin stimulus
// Needs smsc_pkg, smsc_map.svh and smsc_ctrl_chk
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_errors++; \
  $display("ERROR %0t mismatch", $time); end end
module system_mode_standby_control_tb;
  logic clk = 0, rst_n = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0, slv;
  logic mode_pin_hi = 1, mode_pin_lo = 1, standby_pin_n = 1, sleep_exec = 0;
  logic wake_irq = 0, wdt_reset = 0, nmi_in = 1, pready, pslverr, nmi_req, host_en, ram_en;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [1:0] op_mode;
  smsc_pkg::smsc_pwr_s pwr;
  smsc_pkg::smsc_mem_s mem;
  int n_errors = 0, compares = 0, n_nmi = 0, n;
  smsc_ctrl #(.FLASH_VARIANT(1'b1)) dut (.clk, .rst_n, .clk_en, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .mode_pin_hi, .mode_pin_lo, .standby_pin_n,
    .sleep_exec, .wake_irq, .wdt_reset, .nmi_in, .pwr, .mem, .nmi_req, .host_en, .ram_en,
    .op_mode);
  initial forever #20 clk = ~clk;
  always @(posedge clk) if (nmi_req === 1'b1) n_nmi++;
  task test_done;
    if (n_errors == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task cyc(input int k);
    repeat (k) @(posedge clk);
  endtask
  task do_reset(input logic [1:0] m);
    @(posedge clk);
    rst_n <= 1'b0;
    {mode_pin_hi, mode_pin_lo} <= m;
    standby_pin_n <= 1'b1;
    cyc(10);
    rst_n <= 1'b1;
    cyc(3);
  endtask
  task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    int i;
    i = 0;
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      i++;
    end
    while (pready !== 1'b1 && i < 50);
    rd = prdata;
    slv = pslverr;
    {psel, penable} <= 2'b00;
    `CHK(i < 50, 1'b1)
  endtask
  task ev(input bit s);
    @(posedge clk);
    {sleep_exec, wake_irq} <= {s, !s};
    @(posedge clk);
    {sleep_exec, wake_irq} <= 2'b00;
  endtask
  task t_modes;
    for (int m = 1; m < 4; m++)
    begin
      do_reset(m[1:0]);
      `CHK(op_mode, m[1:0])
      apb(0, 16'hFFC5, 0);
      `CHK(rd, 32'hE4 | m)
      `CHK(mem.expanded, m != 3)
      `CHK(mem.ports_gpio, m == 3)
      `CHK(mem.rom_en, m != 1)
    end
  endtask
  task t_regs;
    do_reset(2'h2);
    apb(0, 16'hFFC4, 0);
    `CHK(rd, 32'h09)
    apb(1, 16'hFFC4, 32'h02);
    apb(0, 16'hFFC4, 0);
    `CHK(rd, 32'h0A)
    `CHK({host_en, ram_en, mem.ram_route_ext}, 3'b101)
    apb(1, 16'hFFC5, 32'hFF);
    apb(0, 16'hFFC5, 0);
    `CHK(rd, 32'hE6)
    apb(0, 16'hFFC0, 0);
    `CHK(slv, 1'b1)
    @(posedge clk);
    wdt_reset <= 1'b1;
    @(posedge clk);
    wdt_reset <= 1'b0;
    apb(0, 16'hFFC4, 0);
    `CHK(rd, 32'h01)
  endtask
  task t_nmi;
    for (int e = 0; e < 2; e++)
    begin
      apb(1, 16'hFFC4, e ? 32'h05 : 32'h01);
      nmi_in <= !e;
      cyc(4);
      n = n_nmi;
      nmi_in <= e[0];
      cyc(4);
      nmi_in <= !e;
      cyc(4);
      `CHK(n_nmi - n, 1)
    end
  endtask
  task t_sleep;
    apb(1, 16'hFFC4, 32'h01);
    ev(1);
    cyc(3);
    `CHK({pwr.cpu_halt, pwr.periph_halt}, 2'b10)
    ev(0);
    cyc(3);
    `CHK(pwr.cpu_halt, 1'b0)
    clk_en <= 1'b0;
    ev(1);
    cyc(3);
    `CHK(pwr.cpu_halt, 1'b0)
    clk_en <= 1'b1;
  endtask
  task t_settle;
    int code[2] = '{5, 0};
    int span[2] = '{1024, 8192};
    for (int k = 0; k < 2; k++)
    begin
      apb(1, 16'hFFC4, 32'h81 | (code[k] << 4));
      ev(1);
      cyc(3);
      `CHK({pwr.periph_init, pwr.port_hold, ram_en}, 3'b111)
      ev(0);
      n = 0;
      while (pwr.cpu_halt === 1'b1 && n < 20000)
      begin
        @(negedge clk);
        n++;
      end
      `CHK(n > span[k] - 4 && n < span[k] + 6, 1'b1)
      apb(0, 16'hFFC4, 0);
      `CHK(rd[7], 1'b1)
    end
  endtask
  task t_hstby;
    standby_pin_n <= 1'b0;
    cyc(3);
    `CHK({pwr.port_off, pwr.periph_init}, 2'b11)
    standby_pin_n <= 1'b1;
    cyc(3);
    `CHK(pwr.port_off, 1'b1)
  endtask
  initial
  begin
    t_modes();
    t_regs();
    t_nmi();
    t_sleep();
    t_settle();
    t_hstby();
    test_done();
  end
  initial
  begin
    #(40 * 60000);
    n_errors++;
    test_done();
  end
endmodule
bind smsc_ctrl smsc_ctrl_chk chk (.clk, .rst_n, .clk_en, .psel, .penable, .pready, .pslverr,
  .paddr, .mode_pin_hi, .mode_pin_lo, .standby_pin_n, .wake_irq, .nmi_req, .ram_en, .pwr,
  .mem, .op_mode);
